// *** verilog/cers_pkg.sv ***
// constants, types and register map of the exposure and readout sequencer
package cers_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SETUP   = 8'h04;
  localparam logic [7:0] REG_GAIN    = 8'h08;
  localparam logic [7:0] REG_SHUTTER = 8'h0c;
  localparam logic [7:0] REG_MEMCMD  = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  // control register bit positions
  localparam int CTRL_EXPOSURE_START_PULSE_EN  = 0;
  localparam int CTRL_EXPOSURE_START_PULSE_POS = 1;
  localparam int CTRL_PW_MODE  = 2;
  localparam int CTRL_MULTI    = 3;
  localparam int CTRL_DRAFT    = 4;
  localparam int CTRL_PARTIAL  = 5;
  localparam int CTRL_EXPOSURE_START_PULSE_SRC = 6;
  // memory command fields and codes
  localparam int MEM_BANK_LSB = 0;
  localparam int MEM_OP_LSB   = 2;
  localparam logic [1:0] MEM_OP_SAVE  = 2'h1;
  localparam logic [1:0] MEM_OP_LOAD  = 2'h2;
  localparam logic [1:0] MEM_OP_RESET = 2'h3;
  // live settings, one memory bank holds one copy
  typedef struct packed {
    logic        exposure_start_pulse_src;
    logic        partial;
    logic        draft;
    logic        multi_en;
    logic        pw_mode;
    logic        exposure_start_pulse_pos;
    logic        exposure_start_pulse_en;
    logic [4:0]  setup;
    logic [8:0]  gain;
    logic [10:0] shutter;
  } cers_cfg_s;
  // factory defaults: trigger off, negative polarity, fixed mode, 0 dB
  localparam logic [4:0]  SETUP_RESET   = 5'h1e;
  localparam logic [8:0]  GAIN_RESET    = 9'h000;
  localparam logic [10:0] SHUTTER_RESET = 11'h000;
  localparam cers_cfg_s   CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                        SETUP_RESET, GAIN_RESET, SHUTTER_RESET};
  // black level range in lsb over 32 steps
  localparam int BLACK_MIN  = 88;
  localparam int BLACK_MAX  = 272;
  localparam int SETUP_STEP = 31;
  // sensor geometry
  localparam logic [10:0] PIX_PER_LINE   = 11'd1628;
  localparam logic [10:0] LINES_ALL      = 11'd1236;
  localparam logic [10:0] LINES_PARTIAL  = 11'd552;
  localparam logic [10:0] LINES_DRAFT    = 11'd309;
  localparam logic [10:0] PARTIAL_TOP    = 11'd342;
  localparam logic [10:0] FRAME_ALL      = 11'd1250;
  localparam logic [10:0] FRAME_PARTIAL  = 11'd625;
  localparam logic [10:0] FRAME_DRAFT    = 11'd313;
  // timing, times in ns, counts derived from the 200 MHz clock
  localparam int CLK_PERIOD_NS      = 5;
  localparam int LINE_NS_STD        = 53333;
  localparam int LINE_NS_DRAFT      = 66667;
  localparam int PW_EXTEND_NS       = 28000;
  localparam int BAUD_9600_NS       = 104166;
  localparam int LINE_CYC_STD       = LINE_NS_STD / CLK_PERIOD_NS;
  localparam int LINE_CYC_DRAFT     = LINE_NS_DRAFT / CLK_PERIOD_NS;
  localparam int PW_EXTEND_CYC      = PW_EXTEND_NS / CLK_PERIOD_NS;
  localparam int BAUD_9600_CYC      = BAUD_9600_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BOOT_WAIT  = 2'h3;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_EXPOSE = 3'b001,
    ST_EXTEND = 3'b010,
    ST_HOLD   = 3'b011,
    ST_ALIGN  = 3'b100,
    ST_READ   = 3'b101
  } cers_state_e;
endpackage : cers_pkg

// *** verilog/cers_top.sv ***
// exposure and readout sequencer with wishbone settings port
// Contract
// - settings arrive over the control channel, with save, load and reset of banks
// - black level setup spans 88 to 272 lsb in 32 steps
// - gain spans 0 to +12 dB in 512 steps
// - shutter ranges from the mode frame period down to the shortest exposure
// - trigger has on/off, polarity and fixed or pulse-width method
// - draft readout and partial scan are never on together
// - all-pixel, partial and draft frames have 1236, 552 and 309 lines of 1628
// - partial scan outputs only the 552 centre lines
// - draft readout outputs two lines of every eight over the whole area
// - start pulse comes from the cc1 line or the power sync connector
// - negative polarity starts exposure on the falling edge
// - fixed mode exposure length comes from the shutter setting
// - pulse-width exposure lasts the pulse plus about 28 us
// - triggered frame valid starts with the first line after exposure ends
// - multiple exposure only acts while triggering is on
// - multiple exposure holds the image until a release pulse
// - the release pulse arrives on the cc2 line
// - exposures before a release accumulate into one image
// - each multiple exposure follows the selected trigger method
// - multiple exposure frame valid starts with the first line after release
// - four banks, the power-up bank chosen by two switches
// - serial rate 9600, 19200 or 38400 chosen by switches
//
// The Wishbone register port and the placing of the registers were left to the implementer.
module cers_top
  import cers_pkg::*;
#(
  parameter int LINE_CYC_STD_P   = cers_pkg::LINE_CYC_STD,
  parameter int LINE_CYC_DRAFT_P = cers_pkg::LINE_CYC_DRAFT,
  parameter int PW_EXTEND_CYC_P  = cers_pkg::PW_EXTEND_CYC,
  parameter int BAUD_9600_CYC_P  = cers_pkg::BAUD_9600_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // trigger and release pins
  input  wire logic        cc1_exposure_start,
  input  wire logic        power_sync_connector,
  input  wire logic        cc2_release_n,
  // switches
  input  wire logic        bank_select_switch_low,
  input  wire logic        bank_select_switch_high,
  input  wire logic [1:0]  baud_switch,
  // video framing
  output logic             fval,
  output logic             lval,
  output logic             dval,
  output logic      [10:0] pix_col,
  output logic      [10:0] sensor_row,
  // analogue chain settings and serial bit rate
  output logic      [8:0]  black_level_lsb,
  output logic      [8:0]  gain_code,
  output logic             serial_bit_tick
);
  import cers_pkg::*;

  typedef struct packed {
    cers_state_e           st;
    logic [2:0]            cc1_s;
    logic [2:0]            psc_s;
    logic [2:0]            cc2_s;
    logic [1:0]            bank_lo_s;
    logic [1:0]            bank_hi_s;
    logic [3:0]            baud_s;
    cers_cfg_s             cfg;
    cers_cfg_s [3:0]       bank;
    logic                  rejected;
    logic [1:0]            boot;
    logic [13:0]           h_cnt;
    logic [10:0]           v_cnt;
    logic [10:0]           exp_cnt;
    logic [12:0]           ext_cnt;
    logic [7:0]            exp_num;
    logic [14:0]           baud_cnt;
    logic                  baud_tick;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  fval;
    logic                  lval;
    logic [10:0]           pix_col;
    logic [10:0]           row;
    logic [8:0]            black;
  } cers_regs_s;

  cers_regs_s q, d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // exposure length in lines, held inside one frame period
  function automatic logic [10:0] exp_lines(input logic [10:0] sh, input logic [10:0] fl);
    logic [10:0] r;
    r = sh;
    if (r == 11'h000) begin
      r = fl;
    end else if (r > fl) begin
      r = fl;
    end
    return r;
  endfunction : exp_lines

  // sensor row read out for output line v
  function automatic logic [10:0] row_of(input logic [10:0] v, input logic dr,
                                         input logic pa);
    logic [10:0] r;
    r = v;
    if (pa) begin
      r = PARTIAL_TOP + v;
    end else if (dr) begin
      r = {v[8:1], 2'b00, v[0]};
    end
    return r;
  endfunction : row_of

  function automatic logic [8:0] black_of(input logic [4:0] s);
    logic [15:0] r;
    r = 16'(BLACK_MIN) + 16'((32'(s) * 32'(BLACK_MAX - BLACK_MIN)) / 32'(SETUP_STEP));
    return r[8:0];
  endfunction : black_of

  logic        exposure_start_pulse_lvl;
  logic        exposure_start_pulse_prev;
  logic        exposure_start_pulse_edge;
  logic        exposure_start_pulse_active;
  logic        release_end;
  logic        multi_on;
  logic        line_tick;
  logic [13:0] line_last;
  logic [10:0] frame_lines;
  logic [10:0] out_lines;
  logic        exp_done;
  logic        wb_req;
  logic [31:0] cfg_word;
  logic [31:0] wr_word;
  logic [1:0]  cmd_bank;
  logic [1:0]  cmd_op;
  logic [14:0] baud_last;

  always_comb begin
    d = q;
    // sampled pins: each first sample feeds only the second (baud bits 1:0 feed 3:2), edges compare bits 1 and 2
    d.cc1_s     = {q.cc1_s[1:0], cc1_exposure_start};
    d.psc_s     = {q.psc_s[1:0], power_sync_connector};
    d.cc2_s     = {q.cc2_s[1:0], cc2_release_n};
    d.bank_lo_s = {q.bank_lo_s[0], bank_select_switch_low};
    d.bank_hi_s = {q.bank_hi_s[0], bank_select_switch_high};
    d.baud_s    = {q.baud_s[1:0], baud_switch};

    exposure_start_pulse_lvl    = q.cfg.exposure_start_pulse_src ? q.psc_s[1] : q.cc1_s[1];
    exposure_start_pulse_prev   = q.cfg.exposure_start_pulse_src ? q.psc_s[2] : q.cc1_s[2];
    exposure_start_pulse_edge   = q.cfg.exposure_start_pulse_pos ? (exposure_start_pulse_lvl & ~exposure_start_pulse_prev)
                                 : (~exposure_start_pulse_lvl & exposure_start_pulse_prev);
    exposure_start_pulse_active = q.cfg.exposure_start_pulse_pos ? exposure_start_pulse_lvl : ~exposure_start_pulse_lvl;
    release_end = q.cc2_s[1] & ~q.cc2_s[2];
    multi_on    = q.cfg.exposure_start_pulse_en & q.cfg.multi_en;

    // mode geometry
    line_last   = q.cfg.draft ? 14'(LINE_CYC_DRAFT_P - 1) : 14'(LINE_CYC_STD_P - 1);
    frame_lines = q.cfg.draft ? FRAME_DRAFT : (q.cfg.partial ? FRAME_PARTIAL : FRAME_ALL);
    out_lines   = q.cfg.draft ? LINES_DRAFT : (q.cfg.partial ? LINES_PARTIAL : LINES_ALL);
    line_tick   = (q.h_cnt >= line_last);
    d.h_cnt     = line_tick ? 14'h0000 : q.h_cnt + 14'h0001;

    // serial bit rate from the switches
    case (q.baud_s[3:2])
      2'b01:   baud_last = 15'(BAUD_9600_CYC_P / 2 - 1);
      2'b10:   baud_last = 15'(BAUD_9600_CYC_P / 4 - 1);
      default: baud_last = 15'(BAUD_9600_CYC_P - 1);
    endcase
    d.baud_tick = (q.baud_cnt >= baud_last);
    d.baud_cnt  = d.baud_tick ? 15'h0000 : q.baud_cnt + 15'h0001;

    // fixed exposure ends on a line boundary after the programmed lines
    exp_done = line_tick &&
               (q.exp_cnt + 11'h001 >= exp_lines(q.cfg.shutter, frame_lines));

    case (q.st)
      ST_IDLE: begin
        if (!q.cfg.exposure_start_pulse_en) begin
          if (line_tick) begin
            d.st    = ST_READ;
            d.v_cnt = 11'h000;
          end
        end else if (exposure_start_pulse_edge) begin
          d.st      = ST_EXPOSE;
          d.exp_cnt = 11'h000;
        end
      end
      ST_EXPOSE: begin
        if (!q.cfg.exposure_start_pulse_en) begin
          d.st = ST_IDLE;
        end else if (q.cfg.pw_mode) begin
          // the source keeps the pulse at least a line, no check here
          if (!exposure_start_pulse_active) begin
            d.st      = ST_EXTEND;
            d.ext_cnt = 13'h0000;
          end
        end else begin
          if (line_tick) begin
            d.exp_cnt = q.exp_cnt + 11'h001;
          end
          if (exp_done) begin
            d.st      = multi_on ? ST_HOLD : ST_ALIGN;
            d.exp_num = q.exp_num + 8'h01;
          end
        end
      end
      ST_EXTEND: begin
        d.ext_cnt = q.ext_cnt + 13'h0001;
        if (!q.cfg.exposure_start_pulse_en) begin
          d.st = ST_IDLE;
        end else if (q.ext_cnt >= 13'(PW_EXTEND_CYC_P - 1)) begin
          d.st      = multi_on ? ST_HOLD : ST_ALIGN;
          d.exp_num = q.exp_num + 8'h01;
        end
      end
      ST_HOLD: begin
        // charge keeps adding while further exposures run before release
        if (!multi_on) begin
          d.st = ST_ALIGN;
        end else if (release_end) begin
          d.st = ST_ALIGN;
        end else if (exposure_start_pulse_edge) begin
          d.st      = ST_EXPOSE;
          d.exp_cnt = 11'h000;
        end
      end
      ST_ALIGN: begin
        if (line_tick) begin
          d.st    = ST_READ;
          d.v_cnt = 11'h000;
        end
      end
      ST_READ: begin
        if (line_tick) begin
          d.v_cnt = q.v_cnt + 11'h001;
          if (q.cfg.exposure_start_pulse_en && (q.v_cnt + 11'h001 >= out_lines)) begin
            d.st      = ST_IDLE;
            d.exp_num = 8'h00;
          end else if (q.v_cnt + 11'h001 >= frame_lines) begin
            d.v_cnt = 11'h000;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // framing from next-state values so fval rises with the first lval
    d.fval    = (d.st == ST_READ) && (d.v_cnt < out_lines);
    d.lval    = d.fval && (d.h_cnt < 14'(PIX_PER_LINE));
    d.pix_col = d.lval ? d.h_cnt[10:0] : 11'h000;
    d.row     = row_of(d.v_cnt, q.cfg.draft, q.cfg.partial);

    // register bus, one wait state, ack drops after one cycle
    wb_req   = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack    = wb_req;
    cfg_word = {25'h0, q.cfg.exposure_start_pulse_src, q.cfg.partial, q.cfg.draft, q.cfg.multi_en,
                q.cfg.pw_mode, q.cfg.exposure_start_pulse_pos, q.cfg.exposure_start_pulse_en};
    cmd_bank = wb_dat_i[MEM_BANK_LSB +: 2];
    cmd_op   = wb_dat_i[MEM_OP_LSB +: 2];
    wr_word  = 32'h0;
    if (wb_req) begin
      case (wb_adr_i)
        REG_CTRL:    d.rdat = cfg_word;
        REG_SETUP:   d.rdat = {27'h0, q.cfg.setup};
        REG_GAIN:    d.rdat = {23'h0, q.cfg.gain};
        REG_SHUTTER: d.rdat = {21'h0, q.cfg.shutter};
        REG_STATUS:  d.rdat = {16'h0, q.exp_num, q.rejected, q.st,
                               q.bank_hi_s[1], q.bank_lo_s[1], q.baud_s[3:2]};
        default:     d.rdat = 32'h0;
      endcase
    end
    if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: begin
          wr_word = merge(cfg_word, wb_dat_i, wb_sel_i);
          // both scan modes at once would be illegal: drop the whole write
          if (wr_word[CTRL_DRAFT] && wr_word[CTRL_PARTIAL]) begin
            d.rejected = 1'b1;
          end else begin
            d.rejected       = 1'b0;
            d.cfg.exposure_start_pulse_en    = wr_word[CTRL_EXPOSURE_START_PULSE_EN];
            d.cfg.exposure_start_pulse_pos   = wr_word[CTRL_EXPOSURE_START_PULSE_POS];
            d.cfg.pw_mode    = wr_word[CTRL_PW_MODE];
            d.cfg.multi_en   = wr_word[CTRL_MULTI];
            d.cfg.draft      = wr_word[CTRL_DRAFT];
            d.cfg.partial    = wr_word[CTRL_PARTIAL];
            d.cfg.exposure_start_pulse_src   = wr_word[CTRL_EXPOSURE_START_PULSE_SRC];
          end
        end
        REG_SETUP: begin
          wr_word     = merge({27'h0, q.cfg.setup}, wb_dat_i, wb_sel_i);
          d.cfg.setup = wr_word[4:0];
        end
        REG_GAIN: begin
          wr_word    = merge({23'h0, q.cfg.gain}, wb_dat_i, wb_sel_i);
          d.cfg.gain = wr_word[8:0];
        end
        REG_SHUTTER: begin
          wr_word       = merge({21'h0, q.cfg.shutter}, wb_dat_i, wb_sel_i);
          d.cfg.shutter = wr_word[10:0];
        end
        REG_MEMCMD: begin
          if (wb_sel_i[0]) begin
            case (cmd_op)
              MEM_OP_SAVE:  d.bank[cmd_bank] = q.cfg;
              MEM_OP_LOAD:  d.cfg            = q.bank[cmd_bank];
              MEM_OP_RESET: d.bank[cmd_bank] = CFG_RESET;
              default:      d.rejected       = q.rejected;
            endcase
          end
        end
        default: begin
          d.rejected = q.rejected;
        end
      endcase
    end

    // power-up bank load once the switch samples have settled
    if (q.boot != 2'h0) begin
      d.boot = q.boot - 2'h1;
      if (q.boot == 2'h1) begin
        d.cfg = q.bank[{q.bank_hi_s[1], q.bank_lo_s[1]}];
      end
    end

    d.black = black_of(d.cfg.setup);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.cfg      <= CFG_RESET;
      q.bank     <= {4{CFG_RESET}};
      q.boot     <= BOOT_WAIT;
      // release line idles high, so no false release edge after reset
      q.cc2_s    <= 3'b111;
      q.black    <= 9'h000;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o        = q.rdat;
  assign wb_ack_o        = q.ack;
  assign fval            = q.fval;
  assign lval            = q.lval;
  assign dval            = q.lval;
  assign pix_col         = q.pix_col;
  assign sensor_row      = q.row;
  assign black_level_lsb = q.black;
  assign gain_code       = q.cfg.gain;
  assign serial_bit_tick = q.baud_tick;
endmodule : cers_top

// *** tb/cers_chk.sv ***
// port-level assertions on the exposure and readout sequencer
module cers_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // settings bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // video framing, black level and release
  input wire logic        fval,
  input wire logic        lval,
  input wire logic [10:0] pix_col,
  input wire logic [8:0]  black_level_lsb,
  input wire logic        cc2_release_n
);
  // length of the current lval run, too long to unroll
  logic [11:0] run_q;
  logic [11:0] run_d;
  always_comb run_d = lval ? run_q + 12'h001 : 12'h000;
  always_ff @(posedge clk) begin
    if (!rst_n) run_q <= 12'h000;
    else run_q <= run_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("no ack");
  property p_frame_sync; $rose(fval) |-> $rose(lval); endproperty
  a_frame_sync: assert property (p_frame_sync) else $error("fval off line");
  property p_line_in_frame; lval |-> fval; endproperty
  a_line_in_frame: assert property (p_line_in_frame) else $error("lval outside fval");
  property p_col_idle; !lval |-> pix_col == 11'd0; endproperty
  a_col_idle: assert property (p_col_idle) else $error("column not cleared");
  property p_col_step; lval && $past(lval) |-> pix_col == $past(pix_col) + 11'd1; endproperty
  a_col_step: assert property (p_col_step) else $error("column skipped");
  property p_line_len; $fell(lval) |-> run_q == 12'd1628; endproperty
  a_line_len: assert property (p_line_len) else $error("bad line length");
  property p_black; $past(rst_n) && $past(rst_n, 2) |-> black_level_lsb inside {[9'd88:9'd272]};
  endproperty
  a_black: assert property (p_black) else $error("black level out of range");

  c_frame: cover property ($rose(fval));
  c_release: cover property ($fell(cc2_release_n));
  c_bus: cover property (wb_ack_o);
endmodule : cers_chk

bind cers_top cers_chk u_chk (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .fval(fval), .lval(lval), .pix_col(pix_col), .black_level_lsb(black_level_lsb),
  .cc2_release_n(cc2_release_n)
);

// *** tb/cers_grabber.sv ***
// frame grabber and trigger source model
module cers_grabber (
  // clock
  input wire logic clk,
  // pins toward the camera
  output logic     cc1_exposure_start,
  output logic     power_sync_connector,
  output logic     cc2_release_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cc1_exposure_start   = 1'b0;
    power_sync_connector = 1'b0;
    cc2_release_n        = 1'b1;
  end
  // caller holds the level long enough, a line or more in pulse-width mode
  task automatic drive(input logic src, input logic v);
    @(posedge clk);
    if (src) power_sync_connector <= v;
    else cc1_exposure_start <= v;
  endtask : drive
  // release is active low, width from one line up to 10 ms
  task automatic release_pulse(input int w);
    @(posedge clk);
    cc2_release_n <= 1'b0;
    repeat (w) @(posedge clk);
    cc2_release_n <= 1'b1;
  endtask : release_pulse
endmodule : cers_grabber

// *** tb/tb_cers_top.sv ***
// self-checking bench for the exposure and readout sequencer
module tb_cers_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cers_pkg::*;
  // short lines keep the run small, still longer than 1628
  localparam int LN = 1700;
  localparam int LD = 1800;
  localparam int BD = 64;
  logic             clk, rst_n, cyc, stb, we;
  logic [7:0]       adr;
  logic [31:0]      dat, q;
  logic [1:0]       baud;
  wire logic [31:0] rdat;
  wire logic        ack, fval, lval, dval, tick, cc1, conn, cc2_n;
  wire logic [10:0] col, row;
  wire logic [8:0]  black, gain;
  int               miscompares, check_count, n;

  initial begin
    clk = 1'b0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; dat = 32'h0; miscompares = 0; check_count = 0;
    baud = 2'h2;
  end
  always #2.5 clk = ~clk;

  cers_top #(.LINE_CYC_STD_P(LN), .LINE_CYC_DRAFT_P(LD), .PW_EXTEND_CYC_P(50),
    .BAUD_9600_CYC_P(BD)) uut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cc1_exposure_start(cc1), .power_sync_connector(conn), .cc2_release_n(cc2_n),
    .bank_select_switch_low(1'b1), .bank_select_switch_high(1'b0), .baud_switch(baud),
    .fval(fval), .lval(lval), .dval(dval), .pix_col(col), .sensor_row(row),
    .black_level_lsb(black), .gain_code(gain), .serial_bit_tick(tick));

  cers_grabber u_fg (.clk(clk), .cc1_exposure_start(cc1), .power_sync_connector(conn),
    .cc2_release_n(cc2_n));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 50) chk(32'(k), 32'h0);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  // wait for the next lval start, row and column are then settled
  task automatic line(input int lim);
    n = 0;
    while (lval === 1'b1 && n < lim) begin @(posedge clk); n++; end
    while (lval !== 1'b1 && n < lim) begin @(posedge clk); n++; end
    chk(32'(n < lim), 32'h1);
    chk(32'(dval), 32'h1);
  endtask : line

  // cycles from one serial bit tick to the next
  task automatic tick_gap(input int e);
    n = 0;
    while (tick !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    n = 0;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 200);
    chk(32'(n), 32'(e));
  endtask : tick_gap

  task automatic rst();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : rst

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(REG_CTRL, 32'h0);
    rd(REG_SETUP, 32'h1e);
    chk(32'(black), 32'd266);
    rd(REG_STATUS, 32'h6);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, REG_SETUP, 32'(i * 31));
      repeat (3) @(posedge clk);
      chk(32'(black), i ? 32'd272 : 32'd88);
    end
    wb(1'b1, REG_GAIN, 32'h1ff);
    repeat (3) @(posedge clk);
    chk(32'(gain), 32'h1ff);
    wb(1'b1, REG_GAIN, 32'h155);
    wb(1'b1, REG_MEMCMD, 32'h6);
    wb(1'b1, REG_GAIN, 32'h0);
    wb(1'b1, REG_MEMCMD, 32'ha);
    rd(REG_GAIN, 32'h155);
    wb(1'b1, REG_MEMCMD, 32'he);
    wb(1'b1, REG_MEMCMD, 32'ha);
    rd(REG_GAIN, 32'h0);
    wb(1'b1, REG_CTRL, 32'h20);
    wb(1'b1, REG_CTRL, 32'h30);
    rd(REG_CTRL, 32'h20);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h80, 32'h80);
    tick_gap(BD / 4);
    baud <= 2'h1;
    repeat (4) @(posedge clk);
    tick_gap(BD / 2);
    baud <= 2'h0;
    repeat (4) @(posedge clk);
    tick_gap(BD);
    $display("test settings done");
    // fixed exposure of three lines, partial scan, rising edge on cc1
    wb(1'b1, REG_SHUTTER, 32'h3);
    wb(1'b1, REG_CTRL, 32'h23);
    u_fg.drive(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    u_fg.drive(1'b0, 1'b0);
    line(6 * LN);
    chk(32'(n + 20 >= 2 * LN && n + 20 <= 5 * LN + 20), 32'h1);
    chk(32'(row), 32'd342);
    line(LN + 10);
    chk(32'(row), 32'd343);
    $display("test fixed partial done");
    // draft, negative polarity from the connector: rising edge must not start
    rst();
    wb(1'b1, REG_SHUTTER, 32'h1);
    wb(1'b1, REG_CTRL, 32'h51);
    u_fg.drive(1'b1, 1'b1);
    repeat (4 * LD) @(posedge clk);
    chk(32'(fval), 32'h0);
    u_fg.drive(1'b1, 1'b0);
    line(4 * LD);
    chk(32'(row), 32'd0);
    line(LD + 10);
    chk(32'(row), 32'd1);
    line(LD + 10);
    chk(32'(row), 32'd8);
    $display("test draft done");
    // pulse-width exposure of one line
    rst();
    wb(1'b1, REG_CTRL, 32'h07);
    u_fg.drive(1'b0, 1'b1);
    repeat (LN) @(posedge clk);
    u_fg.drive(1'b0, 1'b0);
    line(3 * LN);
    chk(32'(n >= 50 && n <= 50 + LN + 8), 32'h1);
    chk(32'(row), 32'd0);
    $display("test pulse width done");
    // two exposures held until one release
    rst();
    wb(1'b1, REG_SHUTTER, 32'h1);
    wb(1'b1, REG_CTRL, 32'h0b);
    for (int i = 0; i < 2; i++) begin
      u_fg.drive(1'b0, 1'b1);
      repeat (20) @(posedge clk);
      u_fg.drive(1'b0, 1'b0);
      repeat (4 * LN) @(posedge clk);
    end
    chk(32'(fval), 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(32'(q[15:8]), 32'h2);
    u_fg.release_pulse(LN);
    line(3 * LN);
    chk(32'(n <= LN + 10), 32'h1);
    $display("test multiple exposure done");
    summarize();
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_cers_top
